//--- core/status_output_pkg.sv
// Purpose: Shared constants for the status output function select block
// Assumes: One 100 MHz clock, registers reached by a plain parameter port
// Notes: Function codes and control modes used by mux and top

`default_nettype none

package status_output_pkg;

  // Parameter port offsets (printed word offsets)
  localparam logic [15:0] OUT1_SEL_OFFSET = 16'h0712;
  localparam logic [15:0] OUT2_SEL_OFFSET = 16'h0714;
  localparam logic [15:0] OUT3_SEL_OFFSET = 16'h0716;
  localparam logic [15:0] CHECK_TIME_OFFSET = 16'h0718;
  localparam logic [15:0] MODE_OFFSET = 16'h071a;
  localparam logic [15:0] STATUS_OFFSET = 16'h071c;

  // Values after reset
  localparam logic [15:0] SEL_RESET = 16'h0001;
  localparam logic [15:0] CHECK_TIME_RESET = 16'h0000;
  localparam logic [2:0] MODE_RESET = 3'h0;

  // Window check time base: 1 ms per count
  localparam int CHECK_TICK_NS = 1000000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CHECK_TICK_CYCLES = CHECK_TICK_NS / CLK_PERIOD_NS;

  // Function codes
  localparam logic [15:0] FN_FREE = 16'h0001;
  localparam logic [15:0] FN_NO_ERROR = 16'h0002;
  localparam logic [15:0] FN_READY = 16'h0003;
  localparam logic [15:0] FN_DIR_LOCK = 16'h0004;
  localparam logic [15:0] FN_POS_WIN = 16'h0005;
  localparam logic [15:0] FN_SPD_WIN = 16'h0006;
  localparam logic [15:0] FN_SPD_THR = 16'h0007;
  localparam logic [15:0] FN_CUR_THR = 16'h0008;
  localparam logic [15:0] FN_HALT_ACK = 16'h0009;
  localparam logic [15:0] FN_BRAKE = 16'h000a;
  localparam logic [15:0] FN_SEQ_START = 16'h000b;
  localparam logic [15:0] FN_STANDSTILL = 16'h000d;

  // Control modes: local start-up modes, then fieldbus
  localparam logic [2:0] MODE_JOG = 3'h0;
  localparam logic [2:0] MODE_GEAR = 3'h1;
  localparam logic [2:0] MODE_SPEED = 3'h2;
  localparam logic [2:0] MODE_CURRENT = 3'h3;
  localparam logic [2:0] MODE_SEQUENCE = 3'h4;
  localparam logic [2:0] MODE_FIELDBUS = 3'h5;

  // Status source bundle order
  localparam int SRC_NO_ERROR = 0;
  localparam int SRC_READY = 1;
  localparam int SRC_DIR_LOCK = 2;
  localparam int SRC_POS_WIN = 3;
  localparam int SRC_SPD_WIN = 4;
  localparam int SRC_SPD_THR = 5;
  localparam int SRC_CUR_THR = 6;
  localparam int SRC_HALT_ACK = 7;
  localparam int SRC_BRAKE = 8;
  localparam int SRC_SEQ_START = 9;
  localparam int SRC_STANDSTILL = 10;
  localparam int SRC_COUNT = 11;

endpackage

`default_nettype wire

//--- core/status_src_if.sv
// Purpose: Carries qualified status sources and mode from top to output muxes
// Assumes: Same clock domain as the top
// Notes: One producer (top), several consumers (muxes)

`default_nettype none

interface status_src_if;
  import status_output_pkg::*;
  logic [SRC_COUNT-1:0] src;
  logic [2:0] mode;

  modport producer (output src, output mode);
  modport consumer (input src, input mode);
endinterface

`default_nettype wire

//--- core/output_function_mux.sv
// Purpose: Picks one status source for one signal output by function code
// Assumes: Sources already qualified and synchronous to ref_clk_i
// Notes: Output registered; unoffered codes hold the output inactive

`default_nettype none

module output_function_mux (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Selection and free-use level
  input wire logic [15:0] select_i,
  input wire logic free_level_i,
  status_src_if.consumer srcs,
  // Output
  output logic out_o
);
  import status_output_pkg::*;

  // Offer table per control mode
  function automatic logic offered(input logic [2:0] mode, input logic [15:0] code);
    logic ok;
    ok = 1'b0;
    case (code)
      FN_FREE, FN_NO_ERROR, FN_READY, FN_HALT_ACK, FN_BRAKE, FN_STANDSTILL: ok = (mode <= MODE_FIELDBUS);
      FN_DIR_LOCK: ok = (mode == MODE_GEAR) || (mode == MODE_SPEED);
      FN_POS_WIN: ok = (mode == MODE_GEAR) || (mode == MODE_FIELDBUS);
      FN_SPD_WIN: ok = (mode <= MODE_SPEED) || (mode == MODE_FIELDBUS);
      FN_SPD_THR: ok = (mode <= MODE_CURRENT) || (mode == MODE_FIELDBUS);
      FN_CUR_THR: ok = (mode == MODE_CURRENT) || (mode == MODE_FIELDBUS);
      FN_SEQ_START: ok = (mode == MODE_SEQUENCE);
      default: ok = 1'b0; // Code 12 and others are never offered
    endcase
    return ok;
  endfunction

  logic sel_d;

  // Source selection by code, then masked by the offer table for the mode
  always_comb begin
    case (select_i)
      FN_FREE: sel_d = free_level_i;
      FN_NO_ERROR: sel_d = srcs.src[SRC_NO_ERROR];
      FN_READY: sel_d = srcs.src[SRC_READY];
      FN_DIR_LOCK: sel_d = srcs.src[SRC_DIR_LOCK];
      FN_POS_WIN: sel_d = srcs.src[SRC_POS_WIN];
      FN_SPD_WIN: sel_d = srcs.src[SRC_SPD_WIN];
      FN_SPD_THR: sel_d = srcs.src[SRC_SPD_THR];
      FN_CUR_THR: sel_d = srcs.src[SRC_CUR_THR];
      FN_HALT_ACK: sel_d = srcs.src[SRC_HALT_ACK];
      FN_BRAKE: sel_d = srcs.src[SRC_BRAKE];
      FN_SEQ_START: sel_d = srcs.src[SRC_SEQ_START];
      FN_STANDSTILL: sel_d = srcs.src[SRC_STANDSTILL];
      default: sel_d = 1'b0;
    endcase
    if (!offered(srcs.mode, select_i)) begin
      sel_d = 1'b0;
    end
  end

  // Registered output keeps the pin glitch free
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_o <= 1'b0;
    end else begin
      out_o <= sel_d;
    end
  end

endmodule

`default_nettype wire

//--- core/status_output_function_select.sv
// Purpose: Routes drive status signals to three digital signal outputs
// Assumes: Status inputs synchronous to ref_clk_i; parameter port write/read
// Notes: Window checks need the condition for the check time; threshold inputs pass straight through
//
// Overview of operation
// - Three outputs, each steered by own select
// - Code 1 leaves output free for use
// - Code 2 shows no error present
// - Code 3 shows operating readiness
// - Code 4 shows direction of motion locked
// - Code 5 shows position deviation in window
// - Code 6 shows speed deviation in window
// - Code 7 shows speed below threshold
// - Code 8 shows current below threshold
// - Code 9 acknowledges accepted halt request
// - Code 10 controls motor holding brake
// - Code 11 acknowledges motion-sequence start request
// - Code 13 shows standstill; code 12 refused
// - Local control offers codes by start-up mode
// - Fieldbus offers all but lock and start
// - Window flags need check time held first

`default_nettype none

module status_output_function_select #(
  parameter int CHECK_TICK = status_output_pkg::CHECK_TICK_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Parameter port
  input wire logic param_wr_i,
  input wire logic [15:0] param_addr_i,
  input wire logic [15:0] param_wdata_i,
  output logic [15:0] param_rdata_o,
  // Drive status sources
  input wire logic no_error_i,
  input wire logic ready_i,
  input wire logic dir_locked_i,
  input wire logic pos_in_window_i,
  input wire logic spd_in_window_i,
  input wire logic spd_below_thr_i,
  input wire logic cur_below_thr_i,
  input wire logic halt_ack_i,
  input wire logic brake_release_i,
  input wire logic seq_start_ack_i,
  input wire logic standstill_i,
  // Free-use levels set by the controller
  input wire logic [2:0] free_level_i,
  // Signal outputs
  output logic signal_output_one_o,
  output logic signal_output_two_o,
  output logic signal_output_three_o
);
  import status_output_pkg::*;

  logic [15:0] output1_function_select_q;
  logic [15:0] output2_function_select_q;
  logic [15:0] output3_function_select_q;
  logic [15:0] window_check_time_q;
  logic [2:0] mode_q;
  logic [31:0] tick_cnt_q;
  logic tick;
  logic [15:0] pos_time_q;
  logic [15:0] spd_time_q;
  logic pos_ok_q;
  logic spd_ok_q;
  logic [2:0] outs;

  status_src_if srcs_if ();

  // Parameter writes; the mode field stays in range so the offer table is total
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      output1_function_select_q <= SEL_RESET;
      output2_function_select_q <= SEL_RESET;
      output3_function_select_q <= SEL_RESET;
      window_check_time_q <= CHECK_TIME_RESET;
      mode_q <= MODE_RESET;
    end else if (param_wr_i) begin
      case (param_addr_i)
        OUT1_SEL_OFFSET: output1_function_select_q <= param_wdata_i;
        OUT2_SEL_OFFSET: output2_function_select_q <= param_wdata_i;
        OUT3_SEL_OFFSET: output3_function_select_q <= param_wdata_i;
        CHECK_TIME_OFFSET: window_check_time_q <= param_wdata_i;
        MODE_OFFSET: begin
          if (param_wdata_i[2:0] <= MODE_FIELDBUS) begin
            mode_q <= param_wdata_i[2:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Read back; unmapped offsets read zero
  always_comb begin
    case (param_addr_i)
      OUT1_SEL_OFFSET: param_rdata_o = output1_function_select_q;
      OUT2_SEL_OFFSET: param_rdata_o = output2_function_select_q;
      OUT3_SEL_OFFSET: param_rdata_o = output3_function_select_q;
      CHECK_TIME_OFFSET: param_rdata_o = window_check_time_q;
      MODE_OFFSET: param_rdata_o = {13'h0000, mode_q};
      STATUS_OFFSET: param_rdata_o = {11'h000, pos_ok_q, spd_ok_q, outs};
      default: param_rdata_o = 16'h0000;
    endcase
  end

  // Millisecond tick for the window check time
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick_cnt_q <= 32'h0;
    end else if (tick) begin
      tick_cnt_q <= 32'h0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
    end
  end
  assign tick = (tick_cnt_q == 32'(CHECK_TICK - 1));

  // Position window must hold for the check time; any drop restarts it
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pos_time_q <= 16'h0;
      pos_ok_q <= 1'b0;
    end else if (!pos_in_window_i) begin
      pos_time_q <= 16'h0;
      pos_ok_q <= 1'b0;
    end else begin
      if (tick && pos_time_q < window_check_time_q) begin
        pos_time_q <= pos_time_q + 16'h1;
      end
      pos_ok_q <= (pos_time_q >= window_check_time_q);
    end
  end

  // Speed window, same qualification
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      spd_time_q <= 16'h0;
      spd_ok_q <= 1'b0;
    end else if (!spd_in_window_i) begin
      spd_time_q <= 16'h0;
      spd_ok_q <= 1'b0;
    end else begin
      if (tick && spd_time_q < window_check_time_q) begin
        spd_time_q <= spd_time_q + 16'h1;
      end
      spd_ok_q <= (spd_time_q >= window_check_time_q);
    end
  end

  // Source bundle for the muxes
  always_comb begin
    srcs_if.src = '0;
    srcs_if.src[SRC_NO_ERROR] = no_error_i;
    srcs_if.src[SRC_READY] = ready_i;
    srcs_if.src[SRC_DIR_LOCK] = dir_locked_i;
    srcs_if.src[SRC_POS_WIN] = pos_ok_q;
    srcs_if.src[SRC_SPD_WIN] = spd_ok_q;
    srcs_if.src[SRC_SPD_THR] = spd_below_thr_i;
    srcs_if.src[SRC_CUR_THR] = cur_below_thr_i;
    srcs_if.src[SRC_HALT_ACK] = halt_ack_i;
    srcs_if.src[SRC_BRAKE] = brake_release_i;
    srcs_if.src[SRC_SEQ_START] = seq_start_ack_i;
    srcs_if.src[SRC_STANDSTILL] = standstill_i;
    srcs_if.mode = mode_q;
  end

  // One mux per output
  output_function_mux u_mux1 (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .select_i(output1_function_select_q),
    .free_level_i(free_level_i[0]),
    .srcs(srcs_if.consumer),
    .out_o(outs[0])
  );
  output_function_mux u_mux2 (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .select_i(output2_function_select_q),
    .free_level_i(free_level_i[1]),
    .srcs(srcs_if.consumer),
    .out_o(outs[1])
  );
  output_function_mux u_mux3 (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .select_i(output3_function_select_q),
    .free_level_i(free_level_i[2]),
    .srcs(srcs_if.consumer),
    .out_o(outs[2])
  );

  assign signal_output_one_o = outs[0];
  assign signal_output_two_o = outs[1];
  assign signal_output_three_o = outs[2];

endmodule

`default_nettype wire

//--- sim/status_output_assertions.sv
// Purpose: Concurrent checks on the status output selector ports
// Assumes: One clock, reset active low and asynchronous
// Notes: Shadows output one select and mode to judge output one
`default_nettype none
module status_output_assertions
  import status_output_pkg::*;
#(
  parameter int CHECK_TICK = 4
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Parameter port
  input wire logic param_wr_i,
  input wire logic [15:0] param_addr_i,
  input wire logic [15:0] param_wdata_i,
  input wire logic [15:0] param_rdata_o,
  // Status sources
  input wire logic no_error_i,
  input wire logic dir_locked_i,
  input wire logic halt_ack_i,
  input wire logic [2:0] free_level_i,
  // Outputs
  input wire logic signal_output_one_o,
  input wire logic signal_output_two_o,
  input wire logic signal_output_three_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] sel1_q;
  logic [2:0] mode_q;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // Select shadow, updated on the same edge the block takes a write
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) sel1_q <= SEL_RESET;
    else if (param_wr_i && param_addr_i == OUT1_SEL_OFFSET) sel1_q <= param_wdata_i;
  end
  // Mode shadow; out-of-range modes are dropped just as the block drops them
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) mode_q <= MODE_RESET;
    else if (param_wr_i && param_addr_i == MODE_OFFSET && param_wdata_i[2:0] <= MODE_FIELDBUS)
      mode_q <= param_wdata_i[2:0]; // Only the low field is judged, upper bits are ignored
  end
  reset_outs_a: assert property ($rose(rstn_i) |-> !signal_output_one_o && !signal_output_two_o && !signal_output_three_o)
    else $error("outputs not clear after reset");
  sel_readback_a: assert property (param_wr_i && param_addr_i == OUT1_SEL_OFFSET |=>
    param_addr_i != OUT1_SEL_OFFSET || param_rdata_o == $past(param_wdata_i)) else $error("select readback wrong");
  free_one_a: assert property (sel1_q == FN_FREE |=> signal_output_one_o == $past(free_level_i[0]))
    else $error("free output not following level");
  no_error_a: assert property (sel1_q == FN_NO_ERROR |=> signal_output_one_o == $past(no_error_i))
    else $error("no error output wrong");
  dir_lock_a: assert property (sel1_q == FN_DIR_LOCK && (mode_q == MODE_GEAR || mode_q == MODE_SPEED)
    |=> signal_output_one_o == $past(dir_locked_i)) else $error("direction lock output wrong");
  halt_ack_a: assert property (sel1_q == FN_HALT_ACK |=> signal_output_one_o == $past(halt_ack_i))
    else $error("halt acknowledge output wrong");
  code_gap_a: assert property (sel1_q == 16'h000c || sel1_q == 16'h0000 |=> !signal_output_one_o)
    else $error("refused code drives output");
  bus_start_a: assert property (mode_q == MODE_FIELDBUS && sel1_q == FN_SEQ_START |=> !signal_output_one_o)
    else $error("start acknowledge offered on fieldbus");
  jog_current_a: assert property (mode_q == MODE_JOG && sel1_q == FN_CUR_THR |=> !signal_output_one_o)
    else $error("current threshold offered in jog");
endmodule
bind status_output_function_select status_output_assertions #(.CHECK_TICK(CHECK_TICK)) u_status_output_assertions (
  .ref_clk_i, .rstn_i, .param_wr_i, .param_addr_i, .param_wdata_i, .param_rdata_o, .no_error_i,
  .dir_locked_i, .halt_ack_i, .free_level_i, .signal_output_one_o, .signal_output_two_o, .signal_output_three_o);
`default_nettype wire

//--- sim/output_reader.sv
// Purpose: Machine controller input stage reading the three outputs
// Assumes: Samples on the block clock
// Notes: One cycle of delay, as a real input latch adds
`default_nettype none
module output_reader (
  // Clock
  input wire logic ref_clk_i,
  // Lines and sampled levels
  input wire logic [2:0] lines_i,
  output logic [2:0] seen_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Latch the lines once per clock
  always_ff @(posedge ref_clk_i) begin
    seen_o <= lines_i;
  end
endmodule
`default_nettype wire

//--- sim/status_output_function_select_bench.sv
// Purpose: Self-checking bench for the status output selector
// Assumes: Inputs change on falling edges, short check tick
// Notes: Driver queues expectations, monitor compares them
`default_nettype none
module status_output_function_select_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import status_output_pkg::*;
  logic ref_clk_i = 0, rstn_i = 0, wr = 0;
  logic [15:0] addr = 0, wdata = 0, rdata;
  logic [10:0] src = 0;
  logic [2:0] free = 0, outs, seen;
  logic [16:0] q[$];
  logic [5:0] offer [16] = '{6'h0, 6'h3f, 6'h3f, 6'h3f, 6'h06, 6'h22, 6'h27, 6'h2f,
    6'h28, 6'h3f, 6'h3f, 6'h10, 6'h0, 6'h3f, 6'h0, 6'h0};
  int pick [16] = '{0, 0, 0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 0, 10, 0, 0};
  int bad_count = 0, compares = 0, seed = 32'haa6811c5;
  event probe;
  always #5 ref_clk_i = ~ref_clk_i;
  status_output_function_select #(.CHECK_TICK(4)) u_status_output_function_select (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .param_wr_i(wr), .param_addr_i(addr), .param_wdata_i(wdata),
    .param_rdata_o(rdata), .no_error_i(src[0]), .ready_i(src[1]), .dir_locked_i(src[2]),
    .pos_in_window_i(src[3]), .spd_in_window_i(src[4]), .spd_below_thr_i(src[5]), .cur_below_thr_i(src[6]),
    .halt_ack_i(src[7]), .brake_release_i(src[8]), .seq_start_ack_i(src[9]), .standstill_i(src[10]),
    .free_level_i(free), .signal_output_one_o(outs[0]), .signal_output_two_o(outs[1]),
    .signal_output_three_o(outs[2]));
  output_reader u_output_reader (.ref_clk_i(ref_clk_i), .lines_i(outs), .seen_o(seen));
  // One write, strobe held across exactly one rising edge
  task automatic put(input logic [15:0] a, input logic [15:0] d);
    @(negedge ref_clk_i);
    wr = 1;
    addr = a;
    wdata = d;
    @(negedge ref_clk_i);
    wr = 0;
  endtask
  task automatic note(input logic [16:0] e);
    q.push_back(e);
    -> probe;
  endtask
  // Read data is combinational, so a settle delay is enough
  task automatic peek(input logic [15:0] a, input logic [15:0] e);
    @(negedge ref_clk_i);
    addr = a;
    #1 note({1'b1, e});
  endtask
  task automatic cmp_out(input logic [2:0] e);
    compares++;
    if (seen !== e) begin
      bad_count++;
      $display("BAD %0t outputs %b expected %b", $time, seen, e);
    end
  endtask
  task automatic cmp_rd(input logic [15:0] e);
    compares++;
    if (rdata !== e) begin
      bad_count++;
      $display("BAD %0t read %h expected %h", $time, rdata, e);
    end
  endtask
  // Expected levels from the availability table and current stimulus
  function automatic logic [2:0] want(input int m, input int c1, input int c2, input int c3);
    int c[3];
    c = '{c1, c2, c3};
    for (int k = 0; k < 3; k++) begin
      want[k] = !offer[c[k]][m] ? 1'b0 : c[k] == 1 ? free[k] : src[pick[c[k]]];
    end
  endfunction
  // Monitor takes the oldest note whenever a result is due
  always @(probe) begin
    logic [16:0] e;
    e = q.pop_front();
    if (e[16]) cmp_rd(e[15:0]);
    else cmp_out(e[2:0]);
  end
  task automatic close_out;
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Run takes about 1500 cycles; far above that means a hang
  initial begin
    #200000;
    bad_count++;
    close_out;
  end
  initial begin
    repeat (3) @(negedge ref_clk_i);
    rstn_i = 1;
    peek(OUT3_SEL_OFFSET, SEL_RESET);
    peek(CHECK_TIME_OFFSET, CHECK_TIME_RESET);
    put(16'h0713, 16'h0002);
    peek(OUT1_SEL_OFFSET, SEL_RESET);
    // Every code in every mode, with spread codes on the three outputs
    for (int m = 0; m < 6; m++) begin
      put(MODE_OFFSET, 16'(m));
      for (int c = 0; c < 16; c++) begin
        put(OUT1_SEL_OFFSET, 16'(c));
        put(OUT2_SEL_OFFSET, 16'((c + 5) % 16));
        put(OUT3_SEL_OFFSET, 16'((c + 11) % 16));
        peek(OUT1_SEL_OFFSET, 16'(c));
        repeat (2) begin
          @(negedge ref_clk_i);
          src = 11'($random(seed));
          free = 3'($random(seed));
          repeat (3) @(negedge ref_clk_i);
          note({14'h0, want(m, c, (c + 5) % 16, (c + 11) % 16)});
        end
      end
    end
    // Windows need the check time; a bad mode write leaves gear in place
    src = 11'h000;
    put(MODE_OFFSET, {13'h0, MODE_GEAR});
    put(MODE_OFFSET, 16'h0006);
    peek(MODE_OFFSET, {13'h0, MODE_GEAR});
    put(OUT1_SEL_OFFSET, FN_POS_WIN);
    put(OUT2_SEL_OFFSET, FN_SPD_WIN);
    put(OUT3_SEL_OFFSET, FN_DIR_LOCK);
    put(CHECK_TIME_OFFSET, 16'h0002);
    src = 11'h01c;
    repeat (3) @(negedge ref_clk_i);
    note(17'h00004);
    repeat (12) @(negedge ref_clk_i);
    note(17'h00007);
    src = 11'h014;
    repeat (4) @(negedge ref_clk_i);
    note(17'h00006);
    peek(STATUS_OFFSET, 16'h000e);
    @(negedge ref_clk_i);
    close_out;
  end
endmodule
`default_nettype wire
